// file: dcb_brake_seq.sv
// DC braking sequencer: register file, trigger logic and state machine
// How it works
// R1 - Stop mode 01 brakes without external request
// R2 - Stop braking: run off, frequency at or below threshold
// R3 - Nonzero delay coasts with output off first; here an external request at zero output frequency brakes at once
// R4 - Edge stop braking lasts exactly hold duration
// R5 - Level stop braking holds until run returns
// R6 - Mode 01 may brake at start too
// R7 - Mode 02 selects frequency command braking
// R8 - Mode 02 ignores external brake request
// R9 - Mode 02 brakes when both frequencies low
// R10 - Mode 02 releases at threshold plus 2 Hz
// R11 - Command high at start means no braking
// R12 - Command zero at start begins in braking
// R13 - Edge mode 02 braking lasts hold duration
// R14 - Level mode 02 holds until command rises
// R15 - Level start-in-brake holds until run drops
// R16 - Style 00 edge, 01 level
// R17 - Coast delay spans 0.00 to 5.00 s
// R18 - Hold duration spans 0.00 to 60.00 s
// R19 - Force spans 0 to 100 percent
// R20 - Timers tick 10 ms, restart each episode
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module dcb_brake_seq
    import dcb_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = DCB_TICK_CYCLES
) (
    input wire logic CORE_CLK,            // System clock, 10 MHz
    input wire logic RST,                 // Synchronous reset, high
    input wire logic RUN_CMD,             // Run command level
    input wire logic [15:0] FREQ_CMD,     // Frequency command, 0.01 Hz
    input wire logic [15:0] OUT_FREQ,     // Output frequency, 0.01 Hz
    input wire logic EXT_BRAKE_REQ,       // external_brake_request
    input wire logic [7:0] REG_ADDR,      // Register byte address
    input wire logic [15:0] REG_WDATA,    // Register write data
    input wire logic REG_WR,              // Write strobe
    input wire logic REG_RD,              // Read strobe
    output logic [15:0] REG_RDATA,        // Read data, cycle after strobe
    output logic BRAKE_ACTIVE,            // DC braking applied
    output logic OUTPUT_SHUTOFF,          // Normal output shut off
    output logic [6:0] BRAKE_FORCE        // Force while braking, percent
);

    // ****************************************
    // Declarations
    // ****************************************
    dcb_cfg_type cfg;
    dcb_state_type state, next_state;
    logic run_q;
    logic run_rise;
    logic from_brake;
    logic start_ep;
    logic next_start_ep;
    logic tmr_done;
    logic tmr_restart;
    logic [12:0] tmr_limit;
    logic fc_mode, stop_mode, edge_mode;
    logic ext_ok, stop_trig, fc_cond, fc_release;
    logic trig, level_hold, edge_end;
    logic [16:0] thr_hyst;

    // Strictly-below compare used for both frequencies
    function automatic logic below(input logic [15:0] f, input logic [15:0] t);
        below = (f < t);
    endfunction

    // ****************************************
    // Register writes
    // ****************************************

    // Out-of-range threshold, delay, force and hold writes saturate at the top of their ranges
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            cfg.mode <= DCB_RST_MODE;
            cfg.start_en <= 1'b0;
            cfg.style <= DCB_STYLE_EDGE;
            cfg.thr <= DCB_RST_THR;
            cfg.delay <= DCB_RST_DELAY;
            cfg.force_lvl <= DCB_RST_FORCE;
            cfg.hold <= DCB_RST_HOLD;
        end else if (REG_WR) begin
            case (REG_ADDR)
                DCB_OFS_MODE: begin
                    cfg.mode <= REG_WDATA[1:0];  // R1 R7
                    cfg.start_en <= REG_WDATA[DCB_BIT_START_EN];
                end
                DCB_OFS_THR: begin
                    cfg.thr <= (REG_WDATA > DCB_THR_MAX) ? DCB_THR_MAX : REG_WDATA;
                end
                DCB_OFS_DELAY: begin
                    if (REG_WDATA > 16'(DCB_DELAY_MAX)) begin
                        cfg.delay <= DCB_DELAY_MAX;  // R17
                    end else begin
                        cfg.delay <= REG_WDATA[8:0];
                    end
                end
                DCB_OFS_FORCE: begin
                    if (REG_WDATA > 16'(DCB_FORCE_MAX)) begin
                        cfg.force_lvl <= DCB_FORCE_MAX;  // R19
                    end else begin
                        cfg.force_lvl <= REG_WDATA[6:0];
                    end
                end
                DCB_OFS_HOLD: begin
                    if (REG_WDATA > 16'(DCB_HOLD_MAX)) begin
                        cfg.hold <= DCB_HOLD_MAX;  // R18
                    end else begin
                        cfg.hold <= REG_WDATA[12:0];
                    end
                end
                DCB_OFS_STYLE: begin
                    cfg.style <= REG_WDATA[0];  // R16
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Register reads
    // ****************************************

    // Unmapped addresses read as zero
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                DCB_OFS_MODE: REG_RDATA <= {11'h000, cfg.start_en, 2'h0, cfg.mode};
                DCB_OFS_THR: REG_RDATA <= cfg.thr;
                DCB_OFS_DELAY: REG_RDATA <= {7'h00, cfg.delay};
                DCB_OFS_FORCE: REG_RDATA <= {9'h000, cfg.force_lvl};
                DCB_OFS_HOLD: REG_RDATA <= {3'h0, cfg.hold};
                DCB_OFS_STYLE: REG_RDATA <= {15'h0000, cfg.style};
                DCB_OFS_STATUS: REG_RDATA <= {8'h00, 1'b0, from_brake, start_ep,
                    OUTPUT_SHUTOFF, state};
                default: REG_RDATA <= 16'h0000;
            endcase
        end else begin
            REG_RDATA <= 16'h0000;
        end
    end

    // ****************************************
    // Trigger conditions
    // ****************************************
    assign fc_mode = (cfg.mode == DCB_MODE_FREQ);  // R7
    assign stop_mode = (cfg.mode == DCB_MODE_STOP);  // R1
    assign edge_mode = (cfg.style == DCB_STYLE_EDGE);  // R16
    assign thr_hyst = {1'b0, cfg.thr} + {1'b0, DCB_HYST};

    // External request counts in every mode except 02
    assign ext_ok = EXT_BRAKE_REQ && !fc_mode;  // R8

    // Stop braking: run removed and output at or below threshold
    assign stop_trig = stop_mode && !RUN_CMD && (OUT_FREQ <= cfg.thr);  // R2 R4

    // Frequency-command braking needs run and both frequencies low
    assign fc_cond = fc_mode && RUN_CMD && below(FREQ_CMD, cfg.thr)
        && below(OUT_FREQ, cfg.thr);  // R9
    assign fc_release = ({1'b0, FREQ_CMD} >= thr_hyst);  // R10

    assign trig = ext_ok || stop_trig || fc_cond;

    // Level style: what keeps braking alive once it has begun
    always_comb begin
        level_hold = ext_ok;
        if (stop_mode && !RUN_CMD) begin
            level_hold = 1'b1;  // R5
        end
        if (fc_mode && RUN_CMD) begin
            if (from_brake) begin
                level_hold = 1'b1;  // R15
            end else begin
                level_hold = !fc_release;  // R14
            end
        end
    end

    // Edge style: hold time spent, or the command lifted past hysteresis
    assign edge_end = tmr_done || (fc_mode && !from_brake && fc_release);  // R13 R10

    // ****************************************
    // Run edge and start-in-brake tracking
    // ****************************************
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            run_q <= 1'b0;
        end else begin
            run_q <= RUN_CMD;
        end
    end

    assign run_rise = RUN_CMD && !run_q;

    // A mode 02 start with both frequencies low begins in braking; a high one never does
    always_ff @(posedge CORE_CLK) begin
        if (RST || !RUN_CMD) begin
            from_brake <= 1'b0;
        end else if (run_rise && fc_mode) begin
            from_brake <= (FREQ_CMD <= cfg.thr) && (OUT_FREQ <= cfg.thr);  // R11 R12
        end
    end

    // ****************************************
    // Timer
    // ****************************************

    // Every change of state starts a fresh count
    assign tmr_restart = (next_state != state);  // R20
    assign tmr_limit = (state == DCB_ST_COAST) ? {4'h0, cfg.delay} : cfg.hold;

    dcb_tick_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .clk(CORE_CLK),
        .rst(RST),
        .restart(tmr_restart),
        .limit(tmr_limit),
        .expired(tmr_done)
    );

    // ****************************************
    // State machine
    // ****************************************
    always_comb begin
        next_state = state;
        next_start_ep = start_ep;
        case (state)
            DCB_ST_IDLE: begin
                if (run_rise && stop_mode && cfg.start_en) begin
                    next_state = DCB_ST_BRAKE;  // R6
                    next_start_ep = 1'b1;
                end else if (trig) begin
                    // An external request while the shaft is already still skips the coast
                    if (cfg.delay == 9'h000 || (ext_ok && OUT_FREQ == 16'h0000)) begin
                        next_state = DCB_ST_BRAKE;  // R3
                    end else begin
                        next_state = DCB_ST_COAST;  // R3 R17
                    end
                end
            end
            DCB_ST_COAST: begin
                if (!edge_mode && !level_hold) begin
                    next_state = DCB_ST_IDLE;
                end else if (tmr_done) begin
                    next_state = DCB_ST_BRAKE;  // R3
                end
            end
            DCB_ST_BRAKE: begin
                if (start_ep) begin
                    if (tmr_done) begin
                        next_state = DCB_ST_IDLE;  // R6
                        next_start_ep = 1'b0;
                    end
                end else if (edge_mode) begin
                    if (edge_end) begin
                        next_state = DCB_ST_DONE;  // R4 R13
                    end
                end else if (!level_hold) begin
                    next_state = DCB_ST_IDLE;  // R5 R14 R15
                end
            end
            DCB_ST_DONE: begin
                // Wait for the cause to clear so one episode brakes once;
                // a run returning after a timed stop still gets its start brake
                if (run_rise && stop_mode && cfg.start_en) begin
                    next_state = DCB_ST_BRAKE;  // R6
                    next_start_ep = 1'b1;
                end else if (!trig) begin
                    next_state = DCB_ST_IDLE;
                end
            end
            default: begin
                next_state = DCB_ST_IDLE;
                next_start_ep = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state <= DCB_ST_IDLE;
            start_ep <= 1'b0;
        end else begin
            state <= next_state;
            start_ep <= next_start_ep;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************

    // Registered from next state so they line up with the state register
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            BRAKE_ACTIVE <= 1'b0;
            OUTPUT_SHUTOFF <= 1'b0;
            BRAKE_FORCE <= 7'h00;
        end else begin
            BRAKE_ACTIVE <= (next_state == DCB_ST_BRAKE);
            OUTPUT_SHUTOFF <= (next_state == DCB_ST_COAST)
                || (next_state == DCB_ST_BRAKE);  // R3
            BRAKE_FORCE <= (next_state == DCB_ST_BRAKE) ? cfg.force_lvl : 7'h00;  // R19
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    a_stop_brake_start: assert property (  // R2
        state == DCB_ST_IDLE && stop_trig && cfg.delay == 9'h000
        && !(run_rise && cfg.start_en) |=> BRAKE_ACTIVE)
        else $error("stop braking did not start");

    a_coast_before_brake: assert property (  // R3
        state == DCB_ST_IDLE && trig && !run_rise && cfg.delay != 9'h000
        && !(ext_ok && OUT_FREQ == 16'h0000) |=> OUTPUT_SHUTOFF && !BRAKE_ACTIVE)
        else $error("coast phase skipped");

    a_brake_shuts_output: assert property (  // R3
        BRAKE_ACTIVE |-> OUTPUT_SHUTOFF && BRAKE_FORCE == $past(cfg.force_lvl))
        else $error("braking without output shutoff");

    a_edge_hold_end: assert property (  // R4
        state == DCB_ST_BRAKE && edge_mode && !start_ep && tmr_done
        |=> !BRAKE_ACTIVE && state != DCB_ST_BRAKE)
        else $error("edge braking overran its hold time");

    a_level_run_release: assert property (  // R5
        state == DCB_ST_BRAKE && !edge_mode && !start_ep && stop_mode
        && RUN_CMD && !EXT_BRAKE_REQ |=> !BRAKE_ACTIVE)
        else $error("level stop braking did not release");

    a_freq_ignore_ext: assert property (  // R8
        fc_mode && !RUN_CMD && state == DCB_ST_IDLE |=> state == DCB_ST_IDLE)
        else $error("external request acted in frequency mode");

    a_freq_start_gate: assert property (  // R9
        fc_mode && state == DCB_ST_IDLE && next_state != DCB_ST_IDLE |-> fc_cond)
        else $error("frequency braking began without both low");

    a_freq_hyst_release: assert property (  // R10
        fc_mode && state == DCB_ST_BRAKE && RUN_CMD && !from_brake
        && fc_release |=> !BRAKE_ACTIVE)
        else $error("braking held past threshold plus hysteresis");

    a_force_range: assert property (  // R19
        BRAKE_FORCE <= DCB_FORCE_MAX && cfg.delay <= DCB_DELAY_MAX
        && cfg.hold <= DCB_HOLD_MAX)
        else $error("setting beyond its range");

    c_stop_brake: cover property (stop_mode && $rose(BRAKE_ACTIVE));
    c_coast_then_brake: cover property (
        state == DCB_ST_COAST ##1 state == DCB_ST_BRAKE);
    c_freq_release: cover property (
        fc_mode && state == DCB_ST_BRAKE ##1 state == DCB_ST_IDLE);
    c_start_in_brake: cover property (from_brake && BRAKE_ACTIVE);

endmodule
`default_nettype wire

// file: dcb_pkg.sv
// Shared constants and types for the DC braking sequencer
package dcb_pkg;

    // ****************************************
    // Clock and tick timing
    // ****************************************
    localparam int unsigned DCB_CLK_HZ = 10_000_000;
    localparam int unsigned DCB_TICK_MS = 10;
    localparam int unsigned DCB_TICK_CYCLES = DCB_CLK_HZ / 1000 * DCB_TICK_MS;

    // ****************************************
    // Widths and limits (frequency in 0.01 Hz, times in 10 ms ticks)
    // ****************************************
    localparam int DCB_FW = 16;
    localparam logic [15:0] DCB_HYST = 16'h00C8;      // 2.00 Hz
    localparam logic [15:0] DCB_THR_MAX = 16'hE678;   // 590.00 Hz
    localparam logic [8:0] DCB_DELAY_MAX = 9'h1F4;    // 5.00 s
    localparam logic [12:0] DCB_HOLD_MAX = 13'h1770;  // 60.00 s
    localparam logic [6:0] DCB_FORCE_MAX = 7'h64;     // 100 %

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] DCB_OFS_MODE = 8'h00;
    localparam logic [7:0] DCB_OFS_THR = 8'h04;
    localparam logic [7:0] DCB_OFS_DELAY = 8'h08;
    localparam logic [7:0] DCB_OFS_FORCE = 8'h0C;
    localparam logic [7:0] DCB_OFS_HOLD = 8'h10;
    localparam logic [7:0] DCB_OFS_STYLE = 8'h14;
    localparam logic [7:0] DCB_OFS_STATUS = 8'h18;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int DCB_BIT_START_EN = 4;
    localparam logic [1:0] DCB_RST_MODE = 2'h0;
    localparam logic [15:0] DCB_RST_THR = 16'h0032;   // 0.50 Hz
    localparam logic [8:0] DCB_RST_DELAY = 9'h000;
    localparam logic [6:0] DCB_RST_FORCE = 7'h32;     // 50 %
    localparam logic [12:0] DCB_RST_HOLD = 13'h0032;  // 0.50 s

    // ****************************************
    // Mode and style codes
    // ****************************************
    typedef enum logic [1:0] {
        DCB_MODE_OFF = 2'h0,
        DCB_MODE_STOP = 2'h1,
        DCB_MODE_FREQ = 2'h2
    } dcb_mode_type;

    typedef enum logic {
        DCB_STYLE_EDGE = 1'b0,
        DCB_STYLE_LEVEL = 1'b1
    } dcb_style_type;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        DCB_ST_IDLE = 4'b0001,
        DCB_ST_COAST = 4'b0010,
        DCB_ST_BRAKE = 4'b0100,
        DCB_ST_DONE = 4'b1000
    } dcb_state_type;

    // Software settings carried as one bundle
    typedef struct packed {
        logic [1:0] mode;
        logic start_en;
        logic style;
        logic [15:0] thr;
        logic [8:0] delay;
        logic [6:0] force_lvl;
        logic [12:0] hold;
    } dcb_cfg_type;

endpackage

// file: dcb_tick_timer.sv
// Tick timer: 10 ms prescaler and tick counter with restart
`timescale 1ns/10ps
`default_nettype none
module dcb_tick_timer
    import dcb_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = DCB_TICK_CYCLES
) (
    input wire logic clk,             // System clock
    input wire logic rst,             // Synchronous reset
    input wire logic restart,         // Clear prescaler and count
    input wire logic [12:0] limit,    // Ticks to wait
    output logic expired              // Count reached limit
);

    logic [16:0] pre;
    logic [12:0] ticks;
    logic tick;

    // ****************************************
    // Prescaler
    // ****************************************
    assign tick = (pre == 17'(TICK_CYCLES - 1));

    // Restart zeroes the prescaler too, so the first tick is a full period
    always_ff @(posedge clk) begin
        if (rst || restart || tick) begin
            pre <= 17'h0_0000;  // R20
        end else begin
            pre <= pre + 17'h0_0001;
        end
    end

    // Tick count saturates so a long wait cannot wrap
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            ticks <= 13'h0000;  // R20
        end else if (tick && ticks != 13'h1FFF) begin
            ticks <= ticks + 13'h0001;
        end
    end

    assign expired = (ticks >= limit);

    a_restart_zero: assert property (@(posedge clk) disable iff (rst)  // R20
        restart |=> ticks == 13'h0000 && pre == 17'h0_0000)
        else $error("timer not cleared on restart");

endmodule
`default_nettype wire

// file: dcb_drive_model.sv
// Behavioural drive run logic feeding commands and output frequency
`timescale 1ns/10ps
`default_nettype none
module dcb_drive_model
    import dcb_pkg::*;
#(
    parameter logic [15:0] STEP = 16'h0010
) (
    input wire logic clk,             // System clock
    input wire logic rst,             // Synchronous reset
    input wire logic run_req,         // Operator run request
    input wire logic [15:0] cmd_req,  // Operator frequency request
    input wire logic shutoff,         // Sequencer has cut the output
    output logic run_cmd,             // Run command to sequencer
    output logic [15:0] freq_cmd,     // Frequency command to sequencer
    output logic [15:0] out_freq      // Present output frequency
);
    logic [15:0] target;

    // Commands pass straight through, like a keypad latch
    assign run_cmd = run_req;
    assign freq_cmd = cmd_req;
    assign target = run_req ? cmd_req : 16'h0000;

    // Ramp toward target; an open output reads zero since no current flows
    always_ff @(posedge clk) begin
        if (rst || shutoff) begin
            out_freq <= 16'h0000;
        end else if (out_freq + STEP <= target) begin
            out_freq <= out_freq + STEP;
        end else if (out_freq >= target + STEP) begin
            out_freq <= out_freq - STEP;
        end else begin
            out_freq <= target;
        end
    end
endmodule
`default_nettype wire

// file: dcb_brake_seq_tb_top.sv
// Self-checking bench for the DC braking sequencer
`timescale 1ns/10ps
`default_nettype none
module dcb_brake_seq_tb_top
    import dcb_pkg::*;
;
    // ****************************************
    // Signals and instances
    // ****************************************
    localparam int TC = 4;
    logic CORE_CLK = 1'b0;
    logic RST = 1'b1;
    logic EXT_BRAKE_REQ = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [15:0] REG_WDATA = 16'h0000;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic run_req = 1'b0;
    logic [15:0] cmd_req = 16'h0000;
    logic RUN_CMD;
    logic [15:0] FREQ_CMD;
    logic [15:0] OUT_FREQ;
    logic [15:0] REG_RDATA;
    logic BRAKE_ACTIVE;
    logic OUTPUT_SHUTOFF;
    logic [6:0] BRAKE_FORCE;
    logic [31:0] lfsr = 32'h0000_54f3;
    logic [6:0] frc;
    int bad_count = 0;
    int total_checks = 0;
    int n;

    // Free-running 10 MHz clock
    always #50 CORE_CLK = ~CORE_CLK;

    dcb_brake_seq #(.TICK_CYCLES(TC)) uut (.CORE_CLK(CORE_CLK), .RST(RST),
        .RUN_CMD(RUN_CMD), .FREQ_CMD(FREQ_CMD), .OUT_FREQ(OUT_FREQ),
        .EXT_BRAKE_REQ(EXT_BRAKE_REQ), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .BRAKE_ACTIVE(BRAKE_ACTIVE), .OUTPUT_SHUTOFF(OUTPUT_SHUTOFF),
        .BRAKE_FORCE(BRAKE_FORCE));

    dcb_drive_model drive (.clk(CORE_CLK), .rst(RST), .run_req(run_req),
        .cmd_req(cmd_req), .shutoff(OUTPUT_SHUTOFF), .run_cmd(RUN_CMD),
        .freq_cmd(FREQ_CMD), .out_freq(OUT_FREQ));

    // Maximal-length feedback taps
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Verdict and end of run, shared by timeouts
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge CORE_CLK);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        #1;
        chk16(REG_RDATA, exp);
    endtask

    // Bounded wait on brake (sel 0) or shutoff (sel 1); n holds cycles taken
    task automatic wait_for(input logic sel, input logic lvl, input int bound);
        n = 0;
        while ((sel ? OUTPUT_SHUTOFF : BRAKE_ACTIVE) !== lvl && n < bound) begin
            @(posedge CORE_CLK);
            #1;
            n++;
        end
        total_checks++;
        if (n >= bound) begin
            $display("wrong value at %0t: got %h expected %h", $time, ~lvl, lvl);
            bad_count++;
            final_report();
        end
    endtask

    task automatic hold_len();
        n = 0;
        while (BRAKE_ACTIVE === 1'b1 && n < 1000) begin
            @(posedge CORE_CLK);
            #1;
            n++;
        end
        if (n >= 1000) begin
            total_checks++;
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, 1'b1, 1'b0);
            final_report();
        end
    endtask

    // Run up to a random speed, then drop the run command
    task automatic run_stop();
        lfsr = lfsr_next(lfsr);
        run_req <= 1'b1;
        cmd_req <= 16'h0100 + {6'h00, lfsr[9:0]};
        cyc(150);
        run_req <= 1'b0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        cyc(2);
        RST <= 1'b0;
        rdchk(DCB_OFS_MODE, 16'h0000);
        rdchk(DCB_OFS_THR, 16'h0032);
        rdchk(DCB_OFS_DELAY, 16'h0000);
        rdchk(DCB_OFS_FORCE, 16'h0032);
        rdchk(DCB_OFS_HOLD, 16'h0032);
        rdchk(DCB_OFS_STYLE, 16'h0000);
        rdchk(8'h1C, 16'h0000);
        // Out-of-range settings clamp to their limits
        wr(DCB_OFS_THR, 16'hFFFF);
        rdchk(DCB_OFS_THR, 16'hE678);
        wr(DCB_OFS_DELAY, 16'hFFFF);
        rdchk(DCB_OFS_DELAY, 16'h01F4);
        wr(DCB_OFS_HOLD, 16'hFFFF);
        rdchk(DCB_OFS_HOLD, 16'h1770);
        wr(DCB_OFS_FORCE, 16'hFFFF);
        rdchk(DCB_OFS_FORCE, 16'h0064);
        lfsr = lfsr_next(lfsr);
        frc = 7'(lfsr[15:0] % 16'd101);
        wr(DCB_OFS_FORCE, {9'h000, frc});
        rdchk(DCB_OFS_FORCE, {9'h000, frc});
        wr(DCB_OFS_THR, 16'h0032);
        wr(DCB_OFS_HOLD, 16'h0003);
        wr(DCB_OFS_DELAY, 16'h0000);
        $display("test registers done");
        // Stop mode, edge style: timed braking, then stays off
        wr(DCB_OFS_MODE, 16'h0001);
        run_stop();
        wait_for(1'b0, 1'b1, 500);
        chk1(OUTPUT_SHUTOFF, 1'b1);
        chk16({9'h000, BRAKE_FORCE}, {9'h000, frc});
        hold_len();
        chk1(n >= 3 * TC - 1 && n <= 3 * TC + 1, 1'b1);
        cyc(30);
        #1;
        chk1(BRAKE_ACTIVE, 1'b0);
        chk16({9'h000, BRAKE_FORCE}, 16'h0000);
        rdchk(DCB_OFS_STATUS, {12'h000, DCB_ST_DONE});
        $display("test stop edge done");
        // Coast delay of two ticks before braking
        wr(DCB_OFS_DELAY, 16'h0002);
        run_stop();
        wait_for(1'b1, 1'b1, 500);
        chk1(BRAKE_ACTIVE, 1'b0);
        wait_for(1'b0, 1'b1, 50);
        chk1(n >= 2 * TC - 2 && n <= 2 * TC + 2, 1'b1);
        wr(DCB_OFS_DELAY, 16'h0000);
        $display("test coast delay done");
        // Level style holds until run returns
        wr(DCB_OFS_STYLE, 16'h0001);
        run_stop();
        wait_for(1'b0, 1'b1, 500);
        cyc(100);
        run_req <= 1'b1;
        #1;
        chk1(BRAKE_ACTIVE, 1'b1);
        wait_for(1'b0, 1'b0, 3);
        $display("test stop level done");
        // Braking at start with start enable set
        wr(DCB_OFS_MODE, 16'h0011);
        wr(DCB_OFS_STYLE, 16'h0000);
        run_req <= 1'b0;
        cyc(150);
        run_req <= 1'b1;
        wait_for(1'b0, 1'b1, 5);
        cyc(50);
        $display("test start brake done");
        // Frequency-command mode, level style
        wr(DCB_OFS_MODE, 16'h0002);
        wr(DCB_OFS_STYLE, 16'h0001);
        run_req <= 1'b0;
        cmd_req <= 16'h0000;
        cyc(200);
        EXT_BRAKE_REQ <= 1'b1;
        cyc(50);
        EXT_BRAKE_REQ <= 1'b0;
        run_req <= 1'b1;
        #1;
        chk1(BRAKE_ACTIVE, 1'b0);
        wait_for(1'b0, 1'b1, 5);
        cyc(1);
        cmd_req <= 16'h0400;
        cyc(100);
        run_req <= 1'b0;
        #1;
        chk1(BRAKE_ACTIVE, 1'b1);
        wait_for(1'b0, 1'b0, 5);
        cyc(50);
        run_req <= 1'b1;
        cyc(100);
        cmd_req <= 16'h0010;
        #1;
        chk1(BRAKE_ACTIVE, 1'b0);
        wait_for(1'b0, 1'b1, 500);
        cyc(1);
        cmd_req <= 16'h0032 + DCB_HYST - 16'h0001;
        cyc(10);
        cmd_req <= 16'h0032 + DCB_HYST;
        #1;
        chk1(BRAKE_ACTIVE, 1'b1);
        wait_for(1'b0, 1'b0, 5);
        // Edge style in frequency-command mode
        wr(DCB_OFS_STYLE, 16'h0000);
        cmd_req <= 16'h0010;
        wait_for(1'b0, 1'b1, 500);
        hold_len();
        chk1(n >= 3 * TC - 1 && n <= 3 * TC + 1, 1'b1);
        $display("test frequency mode done");
        final_report();
    end
endmodule
`default_nettype wire
